// >>> core/spg_engine.sv
`timescale 1ns/1ns
// What this block does
// - A write start pulse with nonzero file count puts the engine into write-transfer-active.
// - Push to write FIFO only while active and almost full is low.
// - Count each push; at end count stop active and push.
// - End count in sectors is file count times decoded per-file size.
// - During reads, pop equals not read FIFO empty.
// - During reads, count each pop and regenerate expected word from count.
// - Sector is 64-bit header in dwords 0-1, pattern in dwords 2-127.
// - Start sector address is first file index times per-file size.
// - Header dword 0 holds sector address; address steps after each sector.
// - End of sector seen from word counter with active push or pop.
// - Three-bit select picks increment, decrement, zeros, ones or LFSR.
// - Increment from address and counter; decrement is its inverse.
// - Look-ahead LFSR makes four 32-bit values per clock.
// - LFSR seed is the low 32 bits of the sector address.
// - Aux LFSR word only feeds next values; header shows upper address.
// - During reads, mismatch between expected and popped word sets fail.
// - FIFO data words are 128 bits wide.
// - Select codes: 000 inc, 001 dec, 010 zeros, 011 ones, 100 LFSR.
// - File size code 000 means 32 MB per file.
module spg_engine
  import spg_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire spg_apb_req_type  apb_req,
  output      spg_apb_rsp_type  apb_rsp,
  output      logic             write_fifo_push,
  output      logic [127:0]     write_fifo_data,
  input  wire logic             write_fifo_almost_full,
  output      logic             read_fifo_pop,
  input  wire logic [127:0]     read_fifo_word,
  input  wire logic             read_fifo_empty,
  output      logic             write_transfer_active,
  output      logic             read_transfer_active,
  output      logic             verify_fail
);

  // ============================================================
  // State
  typedef struct packed {
    logic                  wr_active;
    logic                  rd_active;
    logic                  start_wr;
    logic                  start_rd;
    logic [15:0]           first_file;
    logic [15:0]           file_count;
    logic [2:0]            size_code;
    logic [2:0]            pat_sel;
    logic [SPG_ADDR_W-1:0] end_count;
    logic [SPG_CNT_W-1:0]  word_counter;
    logic [SPG_ADDR_W-1:0] sector_address;
    logic [31:0]           lfsr;
    logic [127:0]          generated_word;
    logic                  fail;
    logic [31:0]           prdata;
    logic                  pslverr;
  } spg_state_type;

  spg_state_type   state_ff;
  spg_state_type   nxt_state;
  spg_pattern_type pat_cur;
  spg_pattern_type pat_nxt;
  logic            adv_wr;
  logic            adv_rd;
  logic            apb_setup;
  logic            apb_access;
  logic            sector_end;
  logic [SPG_ADDR_W-1:0] file_sectors;
  logic [SPG_CNT_W-1:0]  end_words;

  // ============================================================
  // Functions
  function automatic logic [SPG_ADDR_W-1:0] spg_file_sectors(input logic [2:0] code);
    logic [5:0] shift;
    shift = 6'(SPG_SIZE0_LOG2) + {3'h0, code};
    spg_file_sectors = {{(SPG_ADDR_W-1){1'b0}}, 1'b1} << shift;
  endfunction : spg_file_sectors

  function automatic logic [31:0] spg_lfsr_step(input logic [31:0] x);
    spg_lfsr_step = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : spg_lfsr_step

  function automatic spg_pattern_type spg_pattern(
    input logic [2:0]            sel,
    input logic [SPG_ADDR_W-1:0] addr,
    input logic [SPG_CNT_W-1:0]  cnt,
    input logic [31:0]           lfsr
  );
    logic [31:0]     lv [4];
    logic [31:0]     dw [4];
    logic            hdr;
    spg_pattern_type res;
    hdr   = (cnt[SPG_SECTOR_LOG2-1:0] == SPG_SECTOR_FIRST);
    lv[0] = hdr ? addr[31:0] : spg_lfsr_step(lfsr);
    for (int k = 1; k < 4; k++)
    begin
      lv[k] = spg_lfsr_step(lv[k-1]);
    end
    for (int k = 0; k < 4; k++)
    begin
      case (sel)
        SPG_PAT_INC:  dw[k] = {addr[24:0], cnt[4:0], 2'(k)};
        SPG_PAT_DEC:  dw[k] = ~{addr[24:0], cnt[4:0], 2'(k)};
        SPG_PAT_ZERO: dw[k] = 32'h0000_0000;
        SPG_PAT_ONE:  dw[k] = 32'hFFFF_FFFF;
        SPG_PAT_LFSR: dw[k] = lv[k];
        default:      dw[k] = 32'h0000_0000;
      endcase
    end
    if (hdr)
    begin
      dw[0] = addr[31:0];
      dw[1] = {24'h00_0000, addr[SPG_ADDR_W-1:32]};
    end
    res.lfsr = lv[3];
    res.word = {dw[3], dw[2], dw[1], dw[0]};
    spg_pattern = res;
  endfunction : spg_pattern

  // ============================================================
  // Handshake outputs
  assign adv_wr     = state_ff.wr_active & ~write_fifo_almost_full;
  assign adv_rd     = state_ff.rd_active & ~read_fifo_empty;
  assign apb_setup  = apb_req.psel & ~apb_req.penable;
  assign apb_access = apb_req.psel & apb_req.penable;
  assign sector_end = (adv_wr | adv_rd) &
                      (state_ff.word_counter[SPG_SECTOR_LOG2-1:0] == SPG_SECTOR_LAST);
  assign file_sectors = spg_file_sectors(state_ff.size_code);
  assign end_words    = {state_ff.end_count, {SPG_SECTOR_LOG2{1'b0}}};

  assign write_fifo_push       = adv_wr;
  assign write_fifo_data       = state_ff.generated_word;
  assign read_fifo_pop         = adv_rd;
  assign write_transfer_active = state_ff.wr_active;
  assign read_transfer_active  = state_ff.rd_active;
  assign verify_fail           = state_ff.fail;
  assign apb_rsp               = {state_ff.prdata, apb_access, state_ff.pslverr};

  // ============================================================
  // Next state
  always_comb
  begin
    nxt_state          = state_ff;
    nxt_state.start_wr = 1'b0;
    nxt_state.start_rd = 1'b0;
    pat_cur = spg_pattern(state_ff.pat_sel, state_ff.sector_address,
                          state_ff.word_counter, state_ff.lfsr);

    // Register reads, captured in setup phase
    if (apb_setup)
    begin
      nxt_state.pslverr = 1'b0;
      case (apb_req.paddr)
        SPG_REG_CTRL:        nxt_state.prdata = 32'h0000_0000;
        SPG_REG_FIRST_FILE:  nxt_state.prdata = {16'h0000, state_ff.first_file};
        SPG_REG_FILE_COUNT:  nxt_state.prdata = {16'h0000, state_ff.file_count};
        SPG_REG_FILE_SIZE:   nxt_state.prdata = {29'h0000_0000, state_ff.size_code};
        SPG_REG_PATTERN:     nxt_state.prdata = {29'h0000_0000, state_ff.pat_sel};
        SPG_REG_STATUS:      nxt_state.prdata = {29'h0000_0000, state_ff.fail,
                                                 state_ff.rd_active, state_ff.wr_active};
        SPG_REG_WORD_COUNT:  nxt_state.prdata = state_ff.word_counter[31:0];
        SPG_REG_SECTOR_ADDR: nxt_state.prdata = state_ff.sector_address[31:0];
        default:
        begin
          nxt_state.prdata  = 32'h0000_0000;
          nxt_state.pslverr = 1'b1;
        end
      endcase
    end

    // Register writes, taken at the access edge
    if (apb_access && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        SPG_REG_CTRL:
        begin
          nxt_state.start_wr = apb_req.pwdata[SPG_CTRL_WR_START_BIT];
          nxt_state.start_rd = apb_req.pwdata[SPG_CTRL_RD_START_BIT];
        end
        SPG_REG_FIRST_FILE: nxt_state.first_file = apb_req.pwdata[15:0];
        SPG_REG_FILE_COUNT: nxt_state.file_count = apb_req.pwdata[15:0];
        SPG_REG_FILE_SIZE:  nxt_state.size_code  = apb_req.pwdata[2:0];
        SPG_REG_PATTERN:    nxt_state.pat_sel    = apb_req.pwdata[2:0];
        default:            nxt_state.prdata     = state_ff.prdata;
      endcase
    end

    // Word advance on push or pop
    if (adv_wr || adv_rd)
    begin
      nxt_state.word_counter = state_ff.word_counter + 45'h1;
      nxt_state.lfsr         = pat_cur.lfsr;
      if (sector_end)
      begin
        nxt_state.sector_address = state_ff.sector_address + 40'h1;
      end
      if (nxt_state.word_counter == end_words)
      begin
        nxt_state.wr_active = 1'b0;
        nxt_state.rd_active = 1'b0;
      end
    end

    // Starts: reload counter, address and end count
    if (state_ff.start_wr || state_ff.start_rd)
    begin
      nxt_state.word_counter   = {SPG_CNT_W{1'b0}};
      nxt_state.lfsr           = SPG_LFSR_RESET;
      nxt_state.sector_address = SPG_ADDR_W'({24'h00_0000, state_ff.first_file}
                                             * file_sectors);
      nxt_state.end_count      = SPG_ADDR_W'({24'h00_0000, state_ff.file_count}
                                             * file_sectors);
      nxt_state.wr_active      = state_ff.start_wr && (state_ff.file_count != 16'h0000);
      nxt_state.rd_active      = !state_ff.start_wr && (state_ff.file_count != 16'h0000);
      if (state_ff.start_rd && !state_ff.start_wr)
      begin
        nxt_state.fail = 1'b0;
      end
    end

    // Verify, set wins over the clear above
    if (adv_rd && (read_fifo_word != state_ff.generated_word))
    begin
      nxt_state.fail = 1'b1;
    end

    // Next word of the pattern, held while paused
    pat_nxt = spg_pattern(nxt_state.pat_sel, nxt_state.sector_address,
                          nxt_state.word_counter, nxt_state.lfsr);
    nxt_state.generated_word = pat_nxt.word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff            <= '0;
      state_ff.first_file <= SPG_FILE_RESET;
      state_ff.file_count <= SPG_COUNT_RESET;
      state_ff.size_code  <= SPG_SIZE_RESET;
      state_ff.pat_sel    <= SPG_PAT_INC;
      state_ff.lfsr       <= SPG_LFSR_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // Assertions
  sequence seq_start_wr;
    state_ff.start_wr && (state_ff.file_count != 16'h0000);
  endsequence

  sequence seq_loaded;
    (state_ff.word_counter == {SPG_CNT_W{1'b0}}) &&
    (state_ff.sector_address[15:0] == 16'h0000 || state_ff.first_file != 16'h0000);
  endsequence

  sequence seq_start_rd;
    state_ff.start_rd && !state_ff.start_wr && (state_ff.file_count != 16'h0000);
  endsequence

  AST_WR_START: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start_wr |=> state_ff.wr_active ##0 seq_loaded)
    else $error("write start did not begin a transfer");

  AST_PUSH_AFULL: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_almost_full || !state_ff.wr_active |-> !write_fifo_push)
    else $error("push while almost full or idle");

  AST_END_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && (state_ff.word_counter + 45'h1 == end_words)
    |=> !state_ff.wr_active && !write_fifo_push)
    else $error("write did not stop at end count");

  AST_POP_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff.rd_active |-> (read_fifo_pop == !read_fifo_empty))
    else $error("pop does not follow not empty");

  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff.wr_active && write_fifo_almost_full && !state_ff.start_wr && !state_ff.start_rd
    |=> $stable(state_ff.word_counter) && $stable(state_ff.sector_address)
        && $stable(write_fifo_data))
    else $error("state moved while paused");

  AST_ADDR_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    sector_end && !state_ff.start_wr && !state_ff.start_rd
    |=> state_ff.sector_address == $past(state_ff.sector_address) + 40'h1)
    else $error("sector address did not step");

  AST_HEADER: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && (state_ff.word_counter[4:0] == SPG_SECTOR_FIRST)
    |-> write_fifo_data[63:0] == {24'h00_0000, state_ff.sector_address})
    else $error("header does not carry sector address");

  AST_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    read_fifo_pop && (read_fifo_word != write_fifo_data) |=> verify_fail [*2])
    else $error("mismatch did not set fail");

  AST_START_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff.start_rd |=> state_ff.word_counter == {SPG_CNT_W{1'b0}})
    else $error("start did not clear counter");

  AST_RD_START: assert property (@(posedge pclk) disable iff (!presetn)
    seq_start_rd |=> state_ff.rd_active && !state_ff.wr_active)
    else $error("read start did not begin a check");

  AST_PUSH_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && !state_ff.start_wr && !state_ff.start_rd
    |=> state_ff.word_counter == $past(state_ff.word_counter) + 45'h1)
    else $error("push did not step the word counter");

  AST_POP_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    read_fifo_pop && !state_ff.start_wr && !state_ff.start_rd
    |=> state_ff.word_counter == $past(state_ff.word_counter) + 45'h1)
    else $error("pop did not step the word counter");

  AST_ZERO_PAT: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && (state_ff.pat_sel == SPG_PAT_ZERO)
    && (state_ff.word_counter[4:0] != SPG_SECTOR_FIRST)
    |-> write_fifo_data == {4{32'h0000_0000}})
    else $error("zero pattern word not all zeros");

  AST_ONES_PAT: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && (state_ff.pat_sel == SPG_PAT_ONE)
    && (state_ff.word_counter[4:0] != SPG_SECTOR_FIRST)
    |-> write_fifo_data == {4{32'hFFFF_FFFF}})
    else $error("ones pattern word not all ones");

  AST_FAIL_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    verify_fail && !state_ff.start_rd |=> verify_fail)
    else $error("fail flag dropped without a read start");

  AST_IDLE_POP: assert property (@(posedge pclk) disable iff (!presetn)
    !state_ff.rd_active |-> !read_fifo_pop)
    else $error("pop while no read is active");

  AST_INC_PAT: assert property (@(posedge pclk) disable iff (!presetn)
    write_fifo_push && (state_ff.pat_sel == SPG_PAT_INC)
    && (state_ff.word_counter[4:0] != SPG_SECTOR_FIRST)
    |-> write_fifo_data[31:0]
        == {state_ff.sector_address[24:0], state_ff.word_counter[4:0], 2'h0})
    else $error("increment pattern word wrong");

endmodule : spg_engine

// >>> core/spg_pkg.sv
// ============================================================
// Shared constants and types
package spg_pkg;

  // ============================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] SPG_REG_CTRL        = 12'h000;
  localparam logic [11:0] SPG_REG_FIRST_FILE  = 12'h004;
  localparam logic [11:0] SPG_REG_FILE_COUNT  = 12'h008;
  localparam logic [11:0] SPG_REG_FILE_SIZE   = 12'h00C;
  localparam logic [11:0] SPG_REG_PATTERN     = 12'h010;
  localparam logic [11:0] SPG_REG_STATUS      = 12'h014;
  localparam logic [11:0] SPG_REG_WORD_COUNT  = 12'h018;
  localparam logic [11:0] SPG_REG_SECTOR_ADDR = 12'h01C;

  // ============================================================
  // Field positions
  localparam int SPG_CTRL_WR_START_BIT = 0;
  localparam int SPG_CTRL_RD_START_BIT = 1;
  localparam int SPG_STS_WR_ACTIVE_BIT = 0;
  localparam int SPG_STS_RD_ACTIVE_BIT = 1;
  localparam int SPG_STS_FAIL_BIT      = 2;

  // ============================================================
  // Sector layout and size decode
  localparam int           SPG_WORD_W          = 128;
  localparam int           SPG_SECTOR_LOG2     = 5;
  localparam logic [4:0]   SPG_SECTOR_LAST     = 5'h1F;
  localparam logic [4:0]   SPG_SECTOR_FIRST    = 5'h00;
  localparam int           SPG_SIZE0_LOG2      = 16;
  localparam int           SPG_ADDR_W          = 40;
  localparam int           SPG_CNT_W           = 45;
  localparam logic [31:0]  SPG_LFSR_RESET      = 32'h0000_0000;
  localparam logic [2:0]   SPG_SIZE_RESET      = 3'h0;
  localparam logic [15:0]  SPG_FILE_RESET      = 16'h0000;
  localparam logic [15:0]  SPG_COUNT_RESET     = 16'h0001;

  // ============================================================
  // Pattern select codes
  typedef enum logic [2:0] {
    SPG_PAT_INC  = 3'h0,
    SPG_PAT_DEC  = 3'h1,
    SPG_PAT_ZERO = 3'h2,
    SPG_PAT_ONE  = 3'h3,
    SPG_PAT_LFSR = 3'h4
  } spg_pat_type;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } spg_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spg_apb_rsp_type;

  typedef struct packed {
    logic [31:0]  lfsr;
    logic [127:0] word;
  } spg_pattern_type;

endpackage : spg_pkg

// >>> testbench/spg_fifo_model.sv
`timescale 1ns/1ns
// ============================================================
// Write FIFO sink and show-ahead read FIFO replaying stored words
module spg_fifo_model (
  input  wire logic         pclk,
  input  wire logic         write_fifo_push,
  input  wire logic [127:0] write_fifo_data,
  output      logic         write_fifo_almost_full,
  input  wire logic         read_fifo_pop,
  output      logic [127:0] read_fifo_word,
  output      logic         read_fifo_empty,
  input  wire logic         clr_wr,
  input  wire logic         clr_rd,
  input       int           corrupt_idx,
  output      int           wr_cnt,
  output      int           rd_idx,
  output      int           n
);
  logic [127:0] mem [0:63];
  logic [127:0] last;
  logic [2:0]   cyc;

  initial
  begin
    cyc = 3'h0;
    wr_cnt = 0;
    rd_idx = 0;
    last = 128'h0;
  end

  assign n = (wr_cnt < 64) ? wr_cnt : 64;

  // ============================================================
  // Capture pushes, advance on pops
  always @(posedge pclk)
  begin
    cyc <= cyc + 3'h1;
    if (clr_wr)
      wr_cnt <= 0;
    else if (write_fifo_push)
    begin
      if (wr_cnt < 64)
        mem[wr_cnt] <= write_fifo_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (clr_rd)
      rd_idx <= 0;
    else if (read_fifo_pop && !read_fifo_empty)
    begin
      last <= read_fifo_word;
      rd_idx <= rd_idx + 1;
    end
  end

  // ============================================================
  // Stalls, gaps and inverted last word while empty
  always_comb
  begin
    write_fifo_almost_full = (cyc >= 3'h5);
    read_fifo_empty = clr_rd || (rd_idx >= n) || (cyc == 3'h2);
    if (read_fifo_empty)
      read_fifo_word = ~last;
    else
      read_fifo_word = mem[rd_idx] ^ ((rd_idx == corrupt_idx) ? 128'h1 : 128'h0);
  end
endmodule : spg_fifo_model

// >>> testbench/test_spg_engine.sv
`timescale 1ns/1ns
module test_spg_engine
  import spg_pkg::*;
;
  logic            pclk;
  logic            presetn;
  spg_apb_req_type req;
  spg_apb_rsp_type rsp;
  logic            push, af, pop, empty, wact, ract, fail, clr_wr, clr_rd, err;
  logic [127:0]    wdata, rword;
  logic [31:0]     rd;
  int              corrupt_idx, wr_cnt, rd_idx, n, num_errors, num_checks;

  spg_engine dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .write_fifo_push(push), .write_fifo_data(wdata), .write_fifo_almost_full(af),
    .read_fifo_pop(pop), .read_fifo_word(rword), .read_fifo_empty(empty),
    .write_transfer_active(wact), .read_transfer_active(ract), .verify_fail(fail));

  spg_fifo_model far_end (.pclk(pclk), .write_fifo_push(push), .write_fifo_data(wdata),
    .write_fifo_almost_full(af), .read_fifo_pop(pop), .read_fifo_word(rword),
    .read_fifo_empty(empty), .clr_wr(clr_wr), .clr_rd(clr_rd),
    .corrupt_idx(corrupt_idx), .wr_cnt(wr_cnt), .rd_idx(rd_idx), .n(n));

  // ============================================================
  // Tasks
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic cmp(input string what, input logic [127:0] e, input logic [127:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
      num_errors++;
    end
  endtask : cmp

  task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
      num_errors++;
    end
  endtask : cmp32

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.penable <= 1'b0;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst

  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step

  function automatic logic [127:0] exp_word(input logic [2:0] p, input int idx);
    logic [31:0]  a;
    logic [31:0]  x;
    logic [31:0]  v;
    logic [127:0] w;
    int           ws;
    a = 32'h0003_0000 + idx / 32;
    ws = idx % 32;
    x = a;
    for (int s = 0; s < 4 * ws; s++) x = step(x);
    for (int k = 0; k < 4; k++)
    begin
      v = {a[24:0], ws[4:0], k[1:0]};
      case (p)
        SPG_PAT_INC:  w[32*k+:32] = v;
        SPG_PAT_DEC:  w[32*k+:32] = ~v;
        SPG_PAT_ZERO: w[32*k+:32] = 32'h0;
        SPG_PAT_ONE:  w[32*k+:32] = 32'hFFFF_FFFF;
        default:      w[32*k+:32] = x;
      endcase
      x = step(x);
    end
    if (ws == 0)
      w[63:0] = {32'h0, a};
    return w;
  endfunction : exp_word

  task automatic setup(input logic [2:0] p);
    apb(1'b1, SPG_REG_FIRST_FILE, 32'h3);
    apb(1'b1, SPG_REG_PATTERN, {29'h0, p});
  endtask : setup

  task automatic run_read(input logic [2:0] p, input logic bad);
    setup(p);
    corrupt_idx <= bad ? 35 : 1000;
    clr_rd <= 1'b1;
    apb(1'b1, SPG_REG_CTRL, 32'h2);
    clr_rd <= 1'b0;
    for (int i = 0; i < 600 && rd_idx < n; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    apb(1'b0, SPG_REG_STATUS, 32'h0);
    cmp32("status", {29'h0, bad, 2'b10}, rd);
    cmp32("verify_fail", {31'h0, bad}, {31'h0, fail});
    cmp32("active", 32'h2, {30'h0, ract, wact});
  endtask : run_read

  // ============================================================
  // Port monitors
  always @(posedge pclk)
    if (presetn)
    begin
      if (wact === 1'b1)
        cmp32("push", {31'h0, ~af}, {31'h0, push});
      if (ract === 1'b1)
        cmp32("pop", {31'h0, ~empty}, {31'h0, pop});
    end

  // ============================================================
  // Clock, watchdog, tests
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    presetn = 1'b0;
    req = '0;
    clr_wr = 1'b0;
    clr_rd = 1'b0;
    corrupt_idx = 1000;
    num_errors = 0;
    num_checks = 0;
    rst();
    apb(1'b0, SPG_REG_FILE_COUNT, 32'h0);
    cmp32("file_count", 32'h1, rd);
    apb(1'b0, SPG_REG_FIRST_FILE, 32'h0);
    cmp32("first_file", 32'h0, rd);
    apb(1'b0, SPG_REG_PATTERN, 32'h0);
    cmp32("pattern", 32'h0, rd);
    apb(1'b0, SPG_REG_FILE_SIZE, 32'h0);
    cmp32("size_code", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    cmp32("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, SPG_REG_FILE_COUNT, 32'h0);
    apb(1'b1, SPG_REG_CTRL, 32'h1);
    apb(1'b0, SPG_REG_STATUS, 32'h0);
    cmp32("status", 32'h0, rd);
    for (int p = 0; p < 5; p++)
    begin
      rst();
      setup(p[2:0]);
      clr_wr <= 1'b1;
      @(posedge pclk);
      clr_wr <= 1'b0;
      apb(1'b1, SPG_REG_CTRL, 32'h1);
      for (int i = 0; i < 600 && wr_cnt < 40; i++) @(posedge pclk);
      apb(1'b0, SPG_REG_STATUS, 32'h0);
      cmp32("status", 32'h1, rd);
      apb(1'b0, SPG_REG_SECTOR_ADDR, 32'h0);
      cmp32("sector_address", 32'h0003_0001, rd);
      rst();
      for (int i = 0; i < 40; i++)
        cmp("word", exp_word(p[2:0], i), far_end.mem[i]);
      run_read(p[2:0], 1'b0);
      if (p == 4)
      begin
        run_read(3'h4, 1'b1);
        run_read(3'h4, 1'b0);
      end
    end
    give_verdict();
  end
endmodule : test_spg_engine
